// ### hw/mtk_pkg.sv
// package: register map, field layout and carriers of the micro-tick input path
package mtk_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_CH_CTRL_BASE = 12'h000;  // channels 0..5 at base + 4*n
    localparam logic [11:0] OFF_TB_CTRL      = 12'h020;
    localparam logic [11:0] OFF_MUL_CTRL     = 12'h024;
    localparam logic [11:0] OFF_ROUTE_SEL    = 12'h028;
    localparam logic [11:0] OFF_TRIG_STAMP   = 12'h030;
    localparam logic [11:0] OFF_STATE_STAMP  = 12'h034;
    localparam logic [11:0] OFF_TICK_ACC     = 12'h038;
    localparam logic [11:0] OFF_TICK_ADD     = 12'h03c;
    localparam logic [11:0] OFF_MAIN_STAMP   = 12'h040;
    localparam logic [11:0] OFF_CAPT_BASE    = 12'h080;  // capture regs 0..5 at base + 4*n

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CH_ANY_EDGE_BIT   = 14;
    localparam int CH_SRC_SEL_LO     = 8;
    localparam int CH_SLICE_BIT      = 3;
    localparam int CH_RISE_MODE_LO   = 4;
    localparam int CH_FALL_MODE_LO   = 6;
    localparam int CH_RISE_EN_BIT    = 1;
    localparam int CH_FALL_EN_BIT    = 2;
    localparam int CH_EN_BIT         = 0;
    localparam int CH_THR_LO         = 16;
    localparam int TB_SLICE_BIT      = 0;
    localparam int MUL_TRIG_CORR_BIT = 0;
    localparam int MUL_STATE_CORR_BIT= 1;
    localparam int MUL_TICK_BASE_BIT = 2;
    localparam int MUL_SLICE_BIT     = 3;
    localparam int MUL_EN_BIT        = 4;

    // ------------------------------------------------------------
    // widths and constants
    // ------------------------------------------------------------
    localparam int STAMP_FULL_W  = 27;
    localparam int STAMP_W       = 24;
    localparam int THR_W         = 16;
    localparam int WORD_W        = 49;
    localparam int NUM_CH        = 6;
    localparam logic [1:0] SRC_MAIN_STAMP = 2'h0;
    localparam logic [2:0] STATE_CH_MIN   = 3'h1;
    localparam logic [2:0] STATE_CH_MAX   = 3'h5;
    localparam logic [31:0] CH_CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

    // filter modes: immediate, up/down counter, plain counter
    typedef enum logic [1:0] {FLT_IMMEDIATE, FLT_UPDOWN, FLT_COUNT, FLT_RSVD} mtk_flt_mode_t;

    // 49-bit channel edge word: edge level, threshold, stamp
    typedef struct packed {
        logic                  valid;
        logic                  level;
        logic [THR_W-1:0]      thr;
        logic [6:0]            spare;
        logic [STAMP_W-1:0]    stamp;
    } mtk_edge_word_t;

    typedef struct packed {
        logic comp_tick;
        logic uncomp_tick;
    } mtk_tick_pair_t;

endpackage

// ### hw/mtk_input_path.sv
// module: input timer channels, routing and tick multiplier front end
`timescale 1ns/1ns
module mtk_input_path
(
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // clock ticks from the prescaler
    input  wire logic        stamp_clk_tick,
    input  wire logic        fast_tick_clock,
    // input signals
    input  wire logic [5:0]  chan_in,
    // micro ticks, corrected stamps and events
    output logic             comp_tick_a,
    output logic             uncomp_tick_a,
    output logic [23:0]      trig_corr_stamp,
    output logic [23:0]      state_corr_stamp,
    output logic             trig_event,
    output logic             state_event
);

    localparam int SW = mtk_pkg::STAMP_W;
    localparam int TW = mtk_pkg::THR_W;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0]                         ch_ctrl_q [mtk_pkg::NUM_CH];
    logic                                tb_slice_q;
    logic [4:0]                          mul_ctrl_q;
    logic [2:0]                          route_sel_q;
    logic [SW-1:0]                       tick_add_q;
    logic [mtk_pkg::STAMP_FULL_W-1:0]    main_stamp_q;
    logic [SW-1:0]                       capt_q [mtk_pkg::NUM_CH];
    logic [5:0]                          in_q;
    logic [TW-1:0]                       flt_cnt_q [mtk_pkg::NUM_CH];
    logic [5:0]                          flt_lvl_q;
    mtk_pkg::mtk_edge_word_t             word_q [mtk_pkg::NUM_CH];
    logic [SW-1:0]                       trig_stamp_q;
    logic [SW-1:0]                       state_stamp_q;
    logic [SW-1:0]                       tick_acc_q;
    logic [SW-1:0]                       last_add_q;
    logic [7:0]                          pend_q;
    logic                                comp_q;
    logic                                uncomp_q;
    logic                                trig_ev_q;
    logic                                state_ev_q;

    logic apb_wr;
    logic apb_rd;
    assign apb_wr  = psel & penable & pwrite;
    assign apb_rd  = psel & penable & ~pwrite;
    assign pready  = 1'b1;

    // ------------------------------------------------------------
    // main time stamp and distributed slice
    // ------------------------------------------------------------
    logic [SW-1:0] dist_stamp;
    logic [SW-1:0] mul_stamp;
    logic [SW-1:0] ch0_stamp;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            main_stamp_q <= '0;
        else if (stamp_clk_tick)
            main_stamp_q <= main_stamp_q + 27'h1;
    end

    // low slice or upper slice
    function automatic logic [SW-1:0] pick_slice(input logic upper,
                                                 input logic [mtk_pkg::STAMP_FULL_W-1:0] ts);
        pick_slice = upper ? ts[mtk_pkg::STAMP_FULL_W-1 -: SW] : ts[SW-1:0];
    endfunction

    assign dist_stamp = pick_slice(tb_slice_q, main_stamp_q);
    assign ch0_stamp  = pick_slice(ch_ctrl_q[0][mtk_pkg::CH_SLICE_BIT], main_stamp_q);
    assign mul_stamp  = pick_slice(mul_ctrl_q[mtk_pkg::MUL_SLICE_BIT], main_stamp_q);

    // ------------------------------------------------------------
    // input timer channels
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            in_q <= '0;
        else
            in_q <= chan_in;
    end

    genvar g;
    generate
        for (g = 0; g < mtk_pkg::NUM_CH; g++)
        begin : g_ch
            logic [31:0]   c;
            logic          want;
            logic          rising;
            logic [1:0]    mode;
            logic [TW-1:0] thr;
            logic          tick_en;
            logic          fire;
            logic          allow;
            logic [SW-1:0] my_stamp;
            assign c      = ch_ctrl_q[g];
            assign want   = in_q[g];
            assign rising = want & ~flt_lvl_q[g];
            assign mode   = rising ? c[mtk_pkg::CH_RISE_MODE_LO +: 2] : c[mtk_pkg::CH_FALL_MODE_LO +: 2];
            assign thr    = c[mtk_pkg::CH_THR_LO +: TW];
            // filter counts prescaler ticks or micro ticks
            assign tick_en = mul_ctrl_q[mtk_pkg::MUL_TICK_BASE_BIT] ? comp_q : stamp_clk_tick;
            assign fire   = (want != flt_lvl_q[g]) &&
                            ((mode == mtk_pkg::FLT_IMMEDIATE) || (flt_cnt_q[g] >= thr));
            // any-edge capture ignores per-edge enables
            assign allow  = c[mtk_pkg::CH_ANY_EDGE_BIT] ||
                            (rising ? c[mtk_pkg::CH_RISE_EN_BIT] : c[mtk_pkg::CH_FALL_EN_BIT]);
            // channel 0 has its own slice, others take the distributed one
            assign my_stamp = (g == 0) ? ch0_stamp : dist_stamp;

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    flt_cnt_q[g] <= '0;
                    flt_lvl_q[g] <= 1'b0;
                end
                else if (fire)
                begin
                    flt_cnt_q[g] <= '0;
                    flt_lvl_q[g] <= want;
                end
                else if (want == flt_lvl_q[g])
                begin
                    if (mode == mtk_pkg::FLT_UPDOWN && flt_cnt_q[g] != '0 && tick_en)
                        flt_cnt_q[g] <= flt_cnt_q[g] - 16'h1;
                    else if (mode != mtk_pkg::FLT_UPDOWN)
                        flt_cnt_q[g] <= '0;
                end
                else if (tick_en)
                    flt_cnt_q[g] <= flt_cnt_q[g] + 16'h1;
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    capt_q[g] <= '0;
                    word_q[g] <= '0;
                end
                else
                begin
                    word_q[g].valid <= 1'b0;
                    if (fire && allow && c[mtk_pkg::CH_EN_BIT])
                    begin
                        if (c[mtk_pkg::CH_SRC_SEL_LO +: 2] == mtk_pkg::SRC_MAIN_STAMP)
                            capt_q[g] <= my_stamp;
                        word_q[g].valid <= 1'b1;
                        word_q[g].level <= want;
                        word_q[g].thr   <= (mode == mtk_pkg::FLT_IMMEDIATE) ? '0 : thr;
                        word_q[g].spare <= '0;
                        word_q[g].stamp <= (c[mtk_pkg::CH_SRC_SEL_LO +: 2] == mtk_pkg::SRC_MAIN_STAMP)
                                           ? my_stamp : capt_q[g];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // routing
    // ------------------------------------------------------------
    mtk_pkg::mtk_edge_word_t trig_word;
    mtk_pkg::mtk_edge_word_t state_word;
    assign trig_word = word_q[0];
    always_comb
    begin
        state_word = '0;
        if (route_sel_q >= mtk_pkg::STATE_CH_MIN && route_sel_q <= mtk_pkg::STATE_CH_MAX)
            state_word = word_q[route_sel_q];
    end

    // ------------------------------------------------------------
    // multiplier front end: filter correction
    // ------------------------------------------------------------
    logic [SW-1:0] trig_corr;
    logic [SW-1:0] state_corr;
    assign trig_corr  = mul_ctrl_q[mtk_pkg::MUL_TRIG_CORR_BIT]
                        ? SW'(trig_word.stamp - {8'h00, trig_word.thr})
                        : trig_word.stamp;
    assign state_corr = mul_ctrl_q[mtk_pkg::MUL_STATE_CORR_BIT]
                        ? SW'(state_word.stamp - {8'h00, state_word.thr})
                        : state_word.stamp;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trig_stamp_q  <= '0;
            state_stamp_q <= '0;
            trig_ev_q     <= 1'b0;
            state_ev_q    <= 1'b0;
        end
        else
        begin
            trig_ev_q  <= trig_word.valid;
            state_ev_q <= state_word.valid;
            if (trig_word.valid)
                trig_stamp_q <= trig_corr;
            if (state_word.valid)
                state_stamp_q <= state_corr;
        end
    end

    // ------------------------------------------------------------
    // micro tick generation
    // ------------------------------------------------------------
    logic [SW:0] acc_sum;
    logic [SW:0] uacc_sum;
    logic [SW-1:0] uacc_q;
    assign acc_sum  = {1'b0, tick_acc_q} + {1'b0, tick_add_q};
    assign uacc_sum = {1'b0, uacc_q} + {1'b0, last_add_q};

    // accumulator steps on the stamp clock enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_acc_q <= '0;
            uacc_q     <= '0;
            last_add_q <= '0;
            pend_q     <= '0;
            comp_q     <= 1'b0;
            uncomp_q   <= 1'b0;
        end
        else
        begin
            comp_q   <= 1'b0;
            uncomp_q <= 1'b0;
            if (trig_ev_q)
                last_add_q <= tick_add_q;
            if (mul_ctrl_q[mtk_pkg::MUL_EN_BIT] && stamp_clk_tick)
            begin
                tick_acc_q <= acc_sum[SW-1:0];
                uacc_q     <= uacc_sum[SW-1:0];
                uncomp_q   <= uacc_sum[SW];
                if (acc_sum[SW] && trig_word.valid)
                    pend_q <= pend_q + 8'h1;
                else if (acc_sum[SW])
                    comp_q <= 1'b1;
                else if (trig_word.valid && tick_acc_q == '0)
                    pend_q <= pend_q;
            end
            else if (mul_ctrl_q[mtk_pkg::MUL_EN_BIT] && fast_tick_clock && pend_q != '0)
            begin
                comp_q <= 1'b1;
                pend_q <= pend_q - 8'h1;
            end
        end
    end

    assign comp_tick_a      = comp_q;
    assign uncomp_tick_a    = uncomp_q;
    assign trig_corr_stamp  = trig_stamp_q;
    assign state_corr_stamp = state_stamp_q;
    assign trig_event       = trig_ev_q;
    assign state_event      = state_ev_q;

    // ------------------------------------------------------------
    // address decode limits
    // ------------------------------------------------------------
    // channel and capture windows end here, exclusive
    localparam logic [11:0] OFF_CH_END   = 12'h018;
    localparam logic [11:0] OFF_CAPT_END = 12'h098;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    logic [3:0] ch_idx;
    assign ch_idx = paddr[5:2];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < mtk_pkg::NUM_CH; i++)
                ch_ctrl_q[i] <= mtk_pkg::CH_CTRL_RST;
            tb_slice_q  <= 1'b0;
            mul_ctrl_q  <= '0;
            route_sel_q <= mtk_pkg::STATE_CH_MIN;
            tick_add_q  <= '0;
        end
        else if (apb_wr)
        begin
            if (paddr < OFF_CH_END && paddr[1:0] == 2'h0)
                ch_ctrl_q[ch_idx[2:0]] <= pwdata;
            case (paddr)
                mtk_pkg::OFF_TB_CTRL:   tb_slice_q  <= pwdata[mtk_pkg::TB_SLICE_BIT];
                mtk_pkg::OFF_MUL_CTRL:  mul_ctrl_q  <= pwdata[4:0];
                mtk_pkg::OFF_ROUTE_SEL: route_sel_q <= pwdata[2:0];
                mtk_pkg::OFF_TICK_ADD:  tick_add_q  <= pwdata[SW-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    logic        unmapped;
    logic [31:0] rd_d;
    logic [3:0]  cap_idx;
    assign cap_idx = paddr[5:2];

    always_comb
    begin
        rd_d     = mtk_pkg::ZERO_WORD;
        unmapped = 1'b0;
        if (paddr < OFF_CH_END)
            rd_d = ch_ctrl_q[ch_idx[2:0]];
        else if (paddr >= mtk_pkg::OFF_CAPT_BASE && paddr < OFF_CAPT_END)
            rd_d = {8'h00, capt_q[cap_idx[2:0]]};
        else
        begin
            case (paddr)
                mtk_pkg::OFF_TB_CTRL:     rd_d = {31'h0, tb_slice_q};
                mtk_pkg::OFF_MUL_CTRL:    rd_d = {27'h0, mul_ctrl_q};
                mtk_pkg::OFF_ROUTE_SEL:   rd_d = {29'h0, route_sel_q};
                mtk_pkg::OFF_TRIG_STAMP:  rd_d = {8'h00, trig_stamp_q};
                mtk_pkg::OFF_STATE_STAMP: rd_d = {8'h00, state_stamp_q};
                mtk_pkg::OFF_TICK_ACC:    rd_d = {8'h00, tick_acc_q};
                mtk_pkg::OFF_TICK_ADD:    rd_d = {8'h00, tick_add_q};
                mtk_pkg::OFF_MAIN_STAMP:  rd_d = {5'h00, main_stamp_q};
                default:                  unmapped = 1'b1;
            endcase
        end
    end

    assign prdata  = apb_rd ? rd_d : mtk_pkg::ZERO_WORD;
    assign pslverr = psel & penable & unmapped;

endmodule

// ### sim/mtk_input_path_props.sv
// checker: port-level properties of the micro-tick input path
`timescale 1ns/1ns
module mtk_input_path_props
(
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // prescaler ticks and inputs
    input wire logic        stamp_clk_tick,
    input wire logic        fast_tick_clock,
    input wire logic [5:0]  chan_in,
    // results
    input wire logic        comp_tick_a,
    input wire logic        uncomp_tick_a,
    input wire logic [23:0] trig_corr_stamp,
    input wire logic [23:0] state_corr_stamp,
    input wire logic        trig_event,
    input wire logic        state_event
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_access;
        psel && penable;
    endsequence
    sequence s_read;
        s_access ##0 !pwrite;
    endsequence

    a_ready_always: assert property (s_access |-> pready)
        else $error("pready low in access phase");
    a_idle_rdata: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
        else $error("read data not zero outside read access");
    a_err_phase: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    a_err_read_zero: assert property (s_read ##0 pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_trig_update: assert property ($changed(trig_corr_stamp) |-> trig_event)
        else $error("trigger stamp moved without event");
    a_state_update: assert property ($changed(state_corr_stamp) |-> state_event)
        else $error("state stamp moved without event");
    a_reset_quiet: assert property (disable iff (1'b0)
        !presetn |-> !(trig_event || state_event || comp_tick_a || uncomp_tick_a))
        else $error("output active during reset");
    a_comp_paced: assert property (comp_tick_a |-> $past(stamp_clk_tick) || $past(fast_tick_clock))
        else $error("compensated tick without a pacing tick");
    a_uncomp_paced: assert property (uncomp_tick_a |-> $past(stamp_clk_tick))
        else $error("uncompensated tick off the stamp clock");
endmodule

bind mtk_input_path mtk_input_path_props mtk_input_path_props_inst
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .stamp_clk_tick, .fast_tick_clock, .chan_in, .comp_tick_a, .uncomp_tick_a,
    .trig_corr_stamp, .state_corr_stamp, .trig_event, .state_event
);

// ### sim/mtk_tick_src.sv
// model: prescaler side, stamp clock enable and fast tick enable
`timescale 1ns/1ns
module mtk_tick_src
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // stamp divide, zero gives a tick every cycle
    input  wire logic [3:0] div,
    // tick enables
    output logic            stamp_clk_tick,
    output logic            fast_tick_clock
);
    logic [3:0] cnt_q;
    logic [1:0] fcnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q          <= 4'h0;
            stamp_clk_tick <= 1'b0;
        end
        else
        begin
            cnt_q          <= (cnt_q >= div) ? 4'h0 : cnt_q + 4'h1;
            stamp_clk_tick <= (cnt_q >= div);
        end
    end

    // fast enable once in four cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fcnt_q          <= 2'h0;
            fast_tick_clock <= 1'b0;
        end
        else
        begin
            fcnt_q          <= fcnt_q + 2'h1;
            fast_tick_clock <= (fcnt_q == 2'h3);
        end
    end
endmodule

// ### sim/micro_tick_input_capture_path_bench.sv
// bench: registers, routing, correction and micro tick scenarios
`timescale 1ns/1ns
module micro_tick_input_capture_path_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        stamp_clk_tick, fast_tick_clock, comp_tick_a, uncomp_tick_a;
    logic        trig_event, state_event;
    logic [5:0]  chan_in;
    logic [23:0] trig_corr_stamp, state_corr_stamp;
    logic [3:0]  div;
    logic [23:0] cyc = 24'h0;
    int          err_count, n_tests;

    mtk_input_path mtk_input_path_inst
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .stamp_clk_tick, .fast_tick_clock, .chan_in, .comp_tick_a, .uncomp_tick_a,
        .trig_corr_stamp, .state_corr_stamp, .trig_event, .state_event
    );
    mtk_tick_src mtk_tick_src_inst (.pclk, .presetn, .div, .stamp_clk_tick, .fast_tick_clock);

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 24'h1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1)
        begin
            err_count++;
            wrap_up();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // toggle one input, count events and measure stamp against toggle time
    task automatic tog(input int ch, output int nt, output int ns, output logic [23:0] dt);
        logic [23:0] c0;
        @(posedge pclk);
        chan_in <= chan_in ^ (6'h01 << ch);
        c0 = cyc;
        nt = 0;
        ns = 0;
        dt = 24'h0;
        repeat (40)
        begin
            @(posedge pclk);
            #1;
            if (trig_event === 1'b1)
            begin
                nt++;
                dt = trig_corr_stamp - c0;
            end
            if (state_event === 1'b1)
            begin
                ns++;
                dt = state_corr_stamp - c0;
            end
        end
    endtask

    task automatic s_regs;
        logic [31:0] r;
        logic        e;
        apb(1'b0, mtk_pkg::OFF_CH_CTRL_BASE, 32'h0, r, e);
        chk(r, mtk_pkg::CH_CTRL_RST);
        apb(1'b1, mtk_pkg::OFF_CH_CTRL_BASE + 12'h4, 32'h0005_40a7, r, e);
        apb(1'b0, mtk_pkg::OFF_CH_CTRL_BASE + 12'h4, 32'h0, r, e);
        chk(r, 32'h0005_40a7);
        apb(1'b1, 12'hffc, 32'hffff_ffff, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'hffc, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
    endtask

    task automatic s_route;
        logic [31:0] r;
        logic        e;
        logic [23:0] dt;
        int          nt, ns, ch;
        for (ch = 0; ch < 6; ch++)
            apb(1'b1, mtk_pkg::OFF_CH_CTRL_BASE + 12'(4 * ch), 32'h0000_4003, r, e);
        apb(1'b1, mtk_pkg::OFF_ROUTE_SEL, 32'h0, r, e);
        tog(3, nt, ns, dt);
        chk(32'(ns), 32'h0);
        for (ch = 1; ch <= 5; ch++)
        begin
            apb(1'b1, mtk_pkg::OFF_ROUTE_SEL, 32'(ch), r, e);
            tog(ch, nt, ns, dt);
            chk(32'(nt), 32'h0);
            chk(32'(ns), 32'h1);
            tog((ch % 5) + 1, nt, ns, dt);
            chk(32'(ns), 32'h0);
            tog(0, nt, ns, dt);
            chk(32'(nt), 32'h1);
            chk(32'(ns), 32'h0);
        end
        apb(1'b0, mtk_pkg::OFF_CAPT_BASE, 32'h0, r, e);
        chk(r, {8'h00, trig_corr_stamp});
    endtask

    task automatic s_corr;
        logic [31:0] r;
        logic        e;
        logic [23:0] d0, d1, d2, s0, s1;
        int          nt, ns;
        apb(1'b1, mtk_pkg::OFF_CH_CTRL_BASE, 32'h0005_40a3, r, e);
        apb(1'b1, mtk_pkg::OFF_CH_CTRL_BASE + 12'h14, 32'h0005_40a3, r, e);
        apb(1'b1, mtk_pkg::OFF_MUL_CTRL, 32'h10, r, e);
        tog(0, nt, ns, d0);
        chk(32'(nt), 32'h1);
        tog(5, nt, ns, s0);
        chk(32'(ns), 32'h1);
        apb(1'b1, mtk_pkg::OFF_MUL_CTRL, 32'h12, r, e);
        tog(0, nt, ns, d1);
        chk({8'h0, d1}, {8'h0, d0});
        tog(5, nt, ns, s1);
        chk({8'h0, s1}, {8'h0, 24'(s0 - 24'h5)});
        apb(1'b1, mtk_pkg::OFF_MUL_CTRL, 32'h11, r, e);
        tog(0, nt, ns, d2);
        chk({8'h0, d2}, {8'h0, 24'(d0 - 24'h5)});
    endtask

    task automatic s_ticks;
        logic [31:0] r;
        logic        e;
        logic [23:0] dt;
        int          nt, ns, nc, nu;
        div <= 4'h1;
        apb(1'b1, mtk_pkg::OFF_TICK_ADD, 32'h0040_0000, r, e);
        apb(1'b0, mtk_pkg::OFF_TICK_ADD, 32'h0, r, e);
        chk(r, 32'h0040_0000);
        apb(1'b1, mtk_pkg::OFF_MUL_CTRL, 32'h10, r, e);
        tog(0, nt, ns, dt);
        nc = 0;
        nu = 0;
        repeat (160)
        begin
            @(posedge pclk);
            #1;
            nc += (comp_tick_a === 1'b1);
            nu += (uncomp_tick_a === 1'b1);
        end
        chk(32'(nc), 32'd20);
        chk(32'(nu), 32'd20);
    endtask

    initial
    begin
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h0;
        pwdata    = 32'h0;
        chan_in   = 6'h0;
        div       = 4'h0;
        err_count = 0;
        n_tests   = 0;
        presetn   = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_route();
        s_corr();
        s_ticks();
        wrap_up();
    end
endmodule
